// ==== tpd_driver.sv ====
// Triac/PWM driver: registers, period wave, burst and phase-angle firing
`timescale 1ns/1ps
module tpd_driver (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration register writes
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    // Output register writes
    input wire logic out_wr,
    input wire logic [7:0] out_addr,
    input wire logic [7:0] out_wdata,
    // Input register reads
    input wire logic [7:0] in_addr,
    output logic [7:0] in_rdata,
    // Mains synchronisation
    input wire logic mains_sync_a,
    input wire logic mains_sync_b,
    // Power switch drive
    output logic drive_out,
    output logic drive_out_oe,
    // Interrupt request
    output logic irq_out
);
    typedef struct packed {
        logic [7:0] driver_config;
        logic [7:0] irq_config;
        logic [15:0] prescale;
        logic [15:0] pulse_width_value;
        logic [7:0] duty_count;
        logic [7:0] duty_act;
        logic [7:0] tick_cnt;
        logic period_wave;
        logic sync_a_q;
        logic sync_b_q;
        tpd_pkg::tpd_phase_type phase;
        logic [3:0] half;
        logic drive;
        logic irq;
        logic [7:0] rdata;
    } tpd_state_type;

    tpd_state_type s_reg;
    tpd_state_type s_next;

    logic driver_run;
    logic counter_go;
    logic clock_select;
    logic pulse_polarity;
    logic single_sync_select;
    logic [1:0] mode;
    logic is_pwm;
    logic is_burst;
    logic is_phase;
    logic sync_b_sel;
    logic rise_a;
    logic fall_b;
    logic zero_cross;
    logic pre_clear;
    logic pre_en;
    logic pre_tick;
    logic pt_start;
    logic pt_busy;
    logic pt_done;
    logic ev_rise;
    logic ev_fall;
    logic ev_pulse;
    logic level;

    // ****************************************
    // Field decode
    // ****************************************
    assign driver_run = s_reg.driver_config[tpd_pkg::DRIVER_RUN_BIT];
    assign counter_go = s_reg.driver_config[tpd_pkg::COUNTER_GO_BIT];
    assign clock_select = s_reg.driver_config[tpd_pkg::CLOCK_SELECT_BIT];
    assign pulse_polarity = s_reg.driver_config[tpd_pkg::POLARITY_BIT];
    assign single_sync_select = s_reg.driver_config[tpd_pkg::SINGLE_SYNC_BIT];
    assign mode = s_reg.driver_config[tpd_pkg::MODE_HI_BIT:tpd_pkg::MODE_LO_BIT];
    assign is_pwm = (mode == tpd_pkg::MODE_PWM);
    assign is_burst = (mode == tpd_pkg::MODE_BURST);
    assign is_phase = mode[1];

    assign sync_b_sel = single_sync_select ? mains_sync_a : mains_sync_b;
    assign rise_a = mains_sync_a && !s_reg.sync_a_q;
    assign fall_b = s_reg.sync_b_q && !sync_b_sel;
    assign zero_cross = rise_a || fall_b;

    // ****************************************
    // Prescaler and pulse timer
    // ****************************************
    // source select, master clock or mains edges
    // a stopped PWM counter holds its count
    always_comb begin
        pre_en = driver_run && (!is_pwm || counter_go);
        if (!is_phase && clock_select) begin
            pre_en = pre_en && rise_a;
        end
    end
    // Phase delay restarts at a crossing seen in PH_IDLE
    assign pre_clear = !driver_run ||
        (is_phase && s_reg.phase == tpd_pkg::PH_IDLE && zero_cross);

    tpd_prescaler #(.PRE_W(16)) u_prescaler (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(pre_clear),
        .src_en(pre_en),
        .divisor(s_reg.prescale),
        .tick(pre_tick)
    );

    tpd_pulse_timer #(.WID_W(16)) u_pulse_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(!driver_run),
        .start(pt_start),
        .width(s_reg.pulse_width_value),
        .busy(pt_busy),
        .done(pt_done)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        ev_rise = 1'b0;
        ev_fall = 1'b0;
        ev_pulse = 1'b0;
        pt_start = 1'b0;
        level = 1'b0;
        s_next.sync_a_q = mains_sync_a;
        s_next.sync_b_q = sync_b_sel;
        if (cfg_wr) begin
            unique case (cfg_addr)
                tpd_pkg::CFG_IRQ: s_next.irq_config = cfg_wdata;
                tpd_pkg::CFG_PRESCALE_LOW: s_next.prescale[7:0] = cfg_wdata;
                tpd_pkg::CFG_PRESCALE_HIGH: s_next.prescale[15:8] = cfg_wdata;
                tpd_pkg::CFG_DRIVER: s_next.driver_config = cfg_wdata;
                tpd_pkg::CFG_WIDTH_HIGH: s_next.pulse_width_value[15:8] = cfg_wdata;
                tpd_pkg::CFG_WIDTH_LOW: s_next.pulse_width_value[7:0] = cfg_wdata;
                default: ;
            endcase
        end
        if (out_wr && out_addr == tpd_pkg::OUT_DUTY) begin
            s_next.duty_count = out_wdata;
        end
        s_next.rdata = (in_addr == tpd_pkg::IN_DUTY) ? s_reg.duty_count : 8'h00;
        // run bit clear holds everything at rest
        if (!driver_run) begin
            s_next.tick_cnt = 8'h00;
            s_next.duty_act = s_reg.duty_count;
            s_next.period_wave = (s_reg.duty_count != 8'h00);
            s_next.phase = tpd_pkg::PH_IDLE;
            s_next.half = 4'h0;
        end else if (!is_phase) begin
            s_next.phase = tpd_pkg::PH_IDLE;
            if (pre_tick) begin
                if (s_reg.tick_cnt == tpd_pkg::PERIOD_LAST) begin
                    s_next.tick_cnt = 8'h00;
                    s_next.duty_act = s_reg.duty_count;
                    s_next.period_wave = (s_reg.duty_count != 8'h00);
                    ev_rise = 1'b1;
                    ev_fall = (s_reg.duty_count == 8'h00) ||
                        (s_reg.duty_count == tpd_pkg::DUTY_FULL);
                end else begin
                    s_next.tick_cnt = s_reg.tick_cnt + 8'h01;
                    if (s_reg.tick_cnt + 8'h01 == s_reg.duty_act) begin
                        s_next.period_wave = 1'b0;
                        ev_fall = 1'b1;
                    end
                end
            end
            // fire on each crossing in on-time
            // no pulse for zero width or duty
            if (is_burst && zero_cross && s_reg.period_wave &&
                s_reg.pulse_width_value != 16'h0000 && s_reg.duty_act != 8'h00) begin
                pt_start = 1'b1;
                ev_pulse = 1'b1;
            end
        end else begin
            ev_rise = rise_a;
            ev_fall = fall_b;
            unique case (s_reg.phase)
                tpd_pkg::PH_IDLE: begin
                    if (zero_cross) begin
                        s_next.phase = tpd_pkg::PH_DELAY;
                        s_next.tick_cnt = 8'h00;
                        s_next.duty_act = s_reg.duty_count;
                    end
                end
                tpd_pkg::PH_DELAY: begin
                    // delay of duty ticks, then eight pulses
                    if (s_reg.tick_cnt == s_reg.duty_act) begin
                        ev_pulse = 1'b1;
                        s_next.half = 4'h0;
                        if (s_reg.pulse_width_value != 16'h0000) begin
                            pt_start = 1'b1;
                            s_next.phase = tpd_pkg::PH_TRAIN;
                        end else begin
                            s_next.phase = tpd_pkg::PH_IDLE;
                        end
                    end else if (pre_tick) begin
                        s_next.tick_cnt = s_reg.tick_cnt + 8'h01;
                    end
                end
                tpd_pkg::PH_TRAIN: begin
                    if (pt_done) begin
                        if (s_reg.half == tpd_pkg::HALF_LAST) begin
                            s_next.phase = tpd_pkg::PH_IDLE;
                        end else begin
                            s_next.half = s_reg.half + 4'h1;
                            pt_start = 1'b1;
                        end
                    end
                end
                default: s_next.phase = tpd_pkg::PH_IDLE;
            endcase
        end
        if (is_pwm) begin
            level = s_reg.period_wave;
        end else if (is_burst) begin
            level = pt_busy;
        end else begin
            level = (s_reg.phase == tpd_pkg::PH_TRAIN) && !s_reg.half[0];
        end
        s_next.drive = driver_run && (level ^ pulse_polarity);
        s_next.irq = driver_run &&
            ((ev_fall && s_reg.irq_config[tpd_pkg::MASK_FALL_BIT]) ||
            (ev_rise && s_reg.irq_config[tpd_pkg::MASK_RISE_BIT]) ||
            (ev_pulse && s_reg.irq_config[tpd_pkg::MASK_PULSE_BIT]));
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.driver_config <= tpd_pkg::RST_CONFIG;
            s_reg.duty_count <= tpd_pkg::RST_DUTY;
            s_reg.prescale <= tpd_pkg::RST_PRESCALE;
            s_reg.pulse_width_value <= tpd_pkg::RST_WIDTH;
            s_reg.phase <= tpd_pkg::PH_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // pin floats while in reset
    assign drive_out_oe = driver_run;
    assign drive_out = s_reg.drive;
    assign irq_out = s_reg.irq;
    assign in_rdata = s_reg.rdata;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_train_start;
        (s_reg.phase == tpd_pkg::PH_TRAIN) ##1 (drive_out != pulse_polarity);
    endsequence

    AST_MODE_PHASE: assert property (
        (s_reg.phase != tpd_pkg::PH_IDLE && !$past(cfg_wr)) |-> mode[1])
        else $error("phase sequencer active outside phase mode");
    AST_READBACK: assert property (
        (in_addr == tpd_pkg::IN_DUTY) |=> (in_rdata == $past(s_reg.duty_count)))
        else $error("duty readback mismatch");
    AST_PERIOD_WRAP: assert property (
        (driver_run && !is_phase && pre_tick && s_reg.tick_cnt == tpd_pkg::PERIOD_LAST
        && !cfg_wr) |=> (s_reg.tick_cnt == 8'h00 && s_reg.period_wave ==
        ($past(s_reg.duty_count) != 8'h00)))
        else $error("period did not wrap after 255 ticks");
    AST_DUTY_HOLD: assert property (
        (driver_run && !is_phase && !cfg_wr &&
        !(pre_tick && s_reg.tick_cnt == tpd_pkg::PERIOD_LAST)) |=> $stable(s_reg.duty_act))
        else $error("active duty changed mid period");
    AST_TRISTATE: assert property (
        (cfg_wr && cfg_addr == tpd_pkg::CFG_DRIVER &&
        !cfg_wdata[tpd_pkg::DRIVER_RUN_BIT]) |=> (!drive_out_oe ##1 !drive_out))
        else $error("pin driven while in reset");
    AST_PAUSE: assert property (
        (driver_run && is_pwm && !counter_go && !cfg_wr) |=> $stable(s_reg.tick_cnt))
        else $error("stopped counter moved");
    AST_NO_PULSE: assert property (
        (driver_run && is_burst && (s_reg.pulse_width_value == 16'h0000 ||
        s_reg.duty_act == 8'h00)) |-> !pt_start)
        else $error("burst pulse with zero width or duty");
    AST_PHASE_FIRE: assert property (
        (driver_run && is_phase && !cfg_wr && s_reg.phase == tpd_pkg::PH_DELAY &&
        s_reg.tick_cnt == s_reg.duty_act && s_reg.pulse_width_value != 16'h0000)
        |=> seq_train_start)
        else $error("pulse train did not start after delay");
    AST_IRQ_GATE: assert property (
        irq_out |-> ($past(s_reg.irq_config[5:3]) != 3'b000))
        else $error("interrupt raised with all masks closed");
endmodule : tpd_driver

// ==== tpd_pkg.sv ====
// Shared constants and types of the triac/PWM driver
package tpd_pkg;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [7:0] CFG_IRQ = 8'h00;
    localparam logic [7:0] CFG_PRESCALE_LOW = 8'h08;
    localparam logic [7:0] CFG_PRESCALE_HIGH = 8'h09;
    localparam logic [7:0] CFG_DRIVER = 8'h0a;
    localparam logic [7:0] CFG_WIDTH_HIGH = 8'h13;
    localparam logic [7:0] CFG_WIDTH_LOW = 8'h14;
    localparam logic [7:0] OUT_DUTY = 8'h09;
    localparam logic [7:0] IN_DUTY = 8'h11;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int POLARITY_BIT = 0;
    localparam int MODE_LO_BIT = 2;
    localparam int MODE_HI_BIT = 3;
    localparam int CLOCK_SELECT_BIT = 4;
    localparam int COUNTER_GO_BIT = 5;
    localparam int SINGLE_SYNC_BIT = 6;
    localparam int DRIVER_RUN_BIT = 7;
    localparam int MASK_FALL_BIT = 3;
    localparam int MASK_RISE_BIT = 4;
    localparam int MASK_PULSE_BIT = 5;

    // ****************************************
    // Encodings, counts and reset values
    // ****************************************
    localparam logic [1:0] MODE_PWM = 2'b00;
    localparam logic [1:0] MODE_BURST = 2'b01;
    localparam logic [7:0] PERIOD_LAST = 8'hfe;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [3:0] HALF_LAST = 4'hf;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [15:0] RST_PRESCALE = 16'h0000;
    localparam logic [15:0] RST_WIDTH = 16'h0000;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_DELAY = 3'b010,
        PH_TRAIN = 3'b100
    } tpd_phase_type;

endpackage : tpd_pkg

// ==== tpd_prescaler.sv ====
// Divide-by-(N+1) prescaler giving a one-cycle tick
`timescale 1ns/1ps
module tpd_prescaler #(
    parameter int PRE_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic src_en,
    input wire logic [PRE_W-1:0] divisor,
    // Output
    output logic tick
);
    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } tpd_pre_state_type;

    tpd_pre_state_type s_reg;
    tpd_pre_state_type s_next;

    assign tick = !clear && src_en && (s_reg.cnt == divisor);

    always_comb begin
        s_next = s_reg;
        if (clear || tick) begin
            s_next.cnt = '0;
        end else if (src_en) begin
            s_next.cnt = s_reg.cnt + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : tpd_prescaler

// ==== tpd_pulse_timer.sv ====
// One-shot timer measured in master clock cycles
`timescale 1ns/1ps
module tpd_pulse_timer #(
    parameter int WID_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic start,
    input wire logic [WID_W-1:0] width,
    // Status
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [WID_W-1:0] cnt;
    } tpd_pt_state_type;

    tpd_pt_state_type s_reg;
    tpd_pt_state_type s_next;

    assign busy = (s_reg.cnt != '0);
    assign done = (s_reg.cnt == {{(WID_W-1){1'b0}}, 1'b1});

    always_comb begin
        s_next = s_reg;
        if (clear) begin
            s_next.cnt = '0;
        end else if (start) begin
            s_next.cnt = width;
        end else if (busy) begin
            s_next.cnt = s_reg.cnt - {{(WID_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : tpd_pulse_timer

// ==== tpd_mains_model.sv ====
// Mains zero-crossing detector and switch gate seen from the driver pin
`timescale 1ns/1ps
module tpd_mains_model (
    // Clock
    input wire logic mclk,
    // Control
    input wire logic [15:0] half_cycles,
    input wire logic b_alone,
    // Detector outputs
    output logic mains_sync_a,
    output logic mains_sync_b,
    // Driver pin
    input wire logic drive_out,
    input wire logic drive_out_oe,
    output logic pin_level
);
    // ****
    // Mains
    // ****
    logic [15:0] cnt_reg = 16'h0000;
    initial mains_sync_a = 1'b0;
    initial mains_sync_b = 1'b0;
    // edges stay many master cycles apart
    always @(posedge mclk) begin
        if (cnt_reg + 16'h0001 >= half_cycles) begin
            cnt_reg <= 16'h0000;
            mains_sync_a <= ~mains_sync_a;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
    // a rises at one crossing, b falls at the next
    // Freed b pin is not tied, so it chatters every cycle
    always @(posedge mclk) begin
        mains_sync_b <= b_alone ? ~mains_sync_b : mains_sync_a;
    end
    // Pull-down on the gate while the pin floats
    assign pin_level = drive_out_oe ? drive_out : 1'b0;
endmodule : tpd_mains_model

// ==== tb_triac_pwm_driver.sv ====
// Self-checking bench of the triac/PWM driver
`timescale 1ns/1ps
module tb_triac_pwm_driver;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic out_wr = 1'b0;
    logic [7:0] out_addr = 8'h00;
    logic [7:0] out_wdata = 8'h00;
    logic [7:0] in_addr = 8'h00;
    logic [7:0] in_rdata;
    logic mains_sync_a;
    logic mains_sync_b;
    logic drive_out;
    logic drive_out_oe;
    logic irq_out;
    logic pin_level;
    logic [15:0] half = 16'h0005;
    logic b_alone = 1'b0;
    logic [31:0] seed = 32'h58fd6ca5;
    logic [31:0] exp_q[$];
    logic [31:0] res_val;
    logic [31:0] exp_v;
    event res_ev;
    int n_errors = 0;
    int n_tests = 0;

    always #50 mclk = ~mclk;

    tpd_driver u_dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata),
        .in_addr(in_addr), .in_rdata(in_rdata), .mains_sync_a(mains_sync_a),
        .mains_sync_b(mains_sync_b), .drive_out(drive_out), .drive_out_oe(drive_out_oe),
        .irq_out(irq_out));

    tpd_mains_model u_mains (.mclk(mclk), .half_cycles(half), .b_alone(b_alone),
        .mains_sync_a(mains_sync_a), .mains_sync_b(mains_sync_b), .drive_out(drive_out),
        .drive_out_oe(drive_out_oe), .pin_level(pin_level));

    // ****
    // Tasks
    // ****
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic limit_hit;
        n_errors++;
        $display("unexpected wait limit at %0t: expected %h, got %h", $time, 1, 0);
        report_and_stop();
    endtask : limit_hit

    task automatic expect_v(input logic [31:0] e);
        exp_q.push_back(e);
    endtask : expect_v

    task automatic post(input logic [31:0] v);
        res_val = v;
        ->res_ev;
        #1;
    endtask : post

    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask : cfg

    task automatic set_duty(input logic [7:0] d);
        @(posedge mclk);
        out_wr <= 1'b1;
        out_addr <= tpd_pkg::OUT_DUTY;
        out_wdata <= d;
        @(posedge mclk);
        out_wr <= 1'b0;
    endtask : set_duty

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        in_addr <= a;
        repeat (2) @(posedge mclk);
        #1 v = in_rdata;
    endtask : rd

    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (irq_out !== 1'b1 && n < 20000);
        if (n >= 20000) limit_hit();
    endtask : wait_irq

    task automatic wait_rise;
        int k;
        logic last;
        k = 0;
        do begin
            last = mains_sync_a;
            @(posedge mclk);
            k++;
        end while (!(mains_sync_a === 1'b1 && last === 1'b0) && k < 1000);
        if (k >= 1000) limit_hit();
    endtask : wait_rise

    // Counts irq pulses, active pin cycles and pin rises over a fixed span
    task automatic window(input int skip, input int cyc, output int ni, output int nh,
        output int nr);
        logic last;
        repeat (skip) @(posedge mclk);
        ni = 0;
        nh = 0;
        nr = 0;
        last = pin_level;
        repeat (cyc) begin
            @(posedge mclk);
            ni += int'(irq_out === 1'b1);
            nh += int'(pin_level === 1'b1);
            nr += int'(pin_level === 1'b1 && last !== 1'b1);
            last = pin_level;
        end
    endtask : window

    always @(res_ev) begin
        n_tests++;
        exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
        if (res_val !== exp_v) begin
            n_errors++;
            $display("unexpected value at %0t: expected %h, got %h", $time, exp_v, res_val);
        end
    end

    // ****
    // Sequence
    // ****
    initial begin
        int n;
        int ni;
        int nh;
        int nr;
        logic [7:0] v;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        expect_v(0);
        post({31'h0, drive_out_oe});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            set_duty(seed[7:0]);
            expect_v({24'h0, seed[7:0]});
            rd(tpd_pkg::IN_DUTY, v);
            post({24'h0, v});
        end
        seed = lfsr_next(seed);
        rd({1'b1, seed[6:0]}, v);
        expect_v(0);
        post({24'h0, v});
        $display("test registers done");
        cfg(tpd_pkg::CFG_PRESCALE_LOW, 8'h01);
        cfg(tpd_pkg::CFG_PRESCALE_HIGH, 8'h00);
        cfg(tpd_pkg::CFG_IRQ, 8'h10);
        set_duty(8'h02);
        cfg(tpd_pkg::CFG_DRIVER, 8'ha0);
        #1;
        expect_v(1);
        post({31'h0, drive_out_oe});
        wait_irq(n);
        expect_v(1);
        post({31'h0, n >= 508 && n <= 512});
        wait_irq(n);
        expect_v(510);
        post(n);
        window(3, 510, ni, nh, nr);
        expect_v(4);
        post(nh);
        for (int m = 0; m < 4; m++) begin
            cfg(tpd_pkg::CFG_IRQ, {3'b000, m[1:0], 3'b000});
            window(3, 1530, ni, nh, nr);
            expect_v(3 * (m[0] + m[1]));
            post(ni);
        end
        cfg(tpd_pkg::CFG_DRIVER, 8'ha1);
        window(3, 510, ni, nh, nr);
        expect_v(506);
        post(nh);
        cfg(tpd_pkg::CFG_DRIVER, 8'ha0);
        for (int k = 0; k < 2; k++) begin
            set_duty(k ? 8'hff : 8'h00);
            wait_irq(n);
            wait_irq(n);
            window(3, 1530, ni, nh, nr);
            expect_v(3);
            post(ni);
            expect_v(k ? 1530 : 0);
            post(nh);
        end
        cfg(tpd_pkg::CFG_IRQ, 8'h10);
        set_duty(8'hc8);
        wait_irq(n);
        wait_irq(n);
        repeat (100) @(posedge mclk);
        set_duty(8'h02);
        window(3, 200, ni, nh, nr);
        expect_v(200);
        post(nh);
        wait_irq(n);
        window(3, 510, ni, nh, nr);
        expect_v(4);
        post(nh);
        cfg(tpd_pkg::CFG_DRIVER, 8'h80);
        window(3, 1530, ni, nh, nr);
        expect_v(0);
        post(ni);
        cfg(tpd_pkg::CFG_DRIVER, 8'ha0);
        wait_irq(n);
        expect_v(1);
        post({31'h0, n >= 502 && n <= 508});
        cfg(tpd_pkg::CFG_DRIVER, 8'h20);
        window(3, 510, ni, nh, nr);
        expect_v(0);
        post({ni[30:0], drive_out_oe});
        $display("test pwm done");
        cfg(tpd_pkg::CFG_WIDTH_HIGH, 8'h00);
        for (int k = 0; k < 3; k++) begin
            cfg(tpd_pkg::CFG_DRIVER, 8'h00);
            b_alone <= (k == 1);
            cfg(tpd_pkg::CFG_WIDTH_LOW, (k == 2) ? 8'h00 : 8'h03);
            cfg(tpd_pkg::CFG_DRIVER, (k == 1) ? 8'hf4 : 8'hb4);
            wait_irq(n);
            wait_irq(n);
            expect_v(5100);
            post(n);
            window(3, 5100, ni, nh, nr);
            expect_v((k == 2) ? 0 : 8);
            post(nr);
            expect_v((k == 2) ? 0 : 24);
            post(nh);
        end
        // PWM ticking from mains edges
        cfg(tpd_pkg::CFG_DRIVER, 8'h00);
        cfg(tpd_pkg::CFG_DRIVER, 8'hb0);
        wait_irq(n);
        wait_irq(n);
        expect_v(5100);
        post(n);
        $display("test burst done");
        cfg(tpd_pkg::CFG_DRIVER, 8'h00);
        b_alone <= 1'b0;
        half <= 16'h0064;
        cfg(tpd_pkg::CFG_PRESCALE_LOW, 8'h00);
        cfg(tpd_pkg::CFG_WIDTH_LOW, 8'h04);
        cfg(tpd_pkg::CFG_IRQ, 8'h20);
        set_duty(8'h05);
        for (int k = 0; k < 2; k++) begin
            cfg(tpd_pkg::CFG_DRIVER, 8'h00);
            cfg(tpd_pkg::CFG_DRIVER, k ? 8'hac : 8'ha8);
            wait_rise();
            wait_rise();
            window(0, 95, ni, nh, nr);
            expect_v(8);
            post(nr);
            expect_v(32);
            post(nh);
            expect_v(1);
            post(ni);
        end
        $display("test phase done");
        report_and_stop();
    end
endmodule : tb_triac_pwm_driver
